// ---- hw/sst_pkg.sv ----
// Package: register map, reset values, timing constants and carrier types of the SPI slave TX block
package sst_pkg;
  // Register byte offsets
  localparam logic [11:0] OFF_RX_RECEIVED_COUNT = 12'h53c;
  localparam logic [11:0] OFF_TX_BUFFER_POINTER = 12'h544;
  localparam logic [11:0] OFF_TX_MAX_BYTES      = 12'h548;
  localparam logic [11:0] OFF_TX_SENT_COUNT     = 12'h54c;
  localparam logic [11:0] OFF_TX_LIST_TYPE      = 12'h550;
  localparam logic [11:0] OFF_SERIAL_FORMAT     = 12'h554;
  localparam logic [11:0] OFF_IGNORED_FILL      = 12'h55c;
  localparam logic [11:0] OFF_OVERREAD_FILL     = 12'h5c0;
  localparam logic [11:0] OFF_LINK_STATUS       = 12'h5c4;
  // Field positions
  localparam int CFG_BIT_ORDER = 0;
  localparam int CFG_PHASE     = 1;
  localparam int CFG_POLARITY  = 2;
  localparam int STAT_GRANTED  = 0;
  localparam int STAT_SELECTED = 1;
  localparam int STAT_READY    = 2;
  // Reset values
  localparam logic [31:0] RST_POINTER   = 32'h0000_0000;
  localparam logic [15:0] RST_MAX_BYTES = 16'h0000;
  localparam logic [15:0] RST_COUNT     = 16'h0000;
  localparam logic [1:0]  RST_LIST      = 2'h0;
  localparam logic [2:0]  RST_CONFIG    = 3'h0;
  localparam logic [7:0]  RST_FILL      = 8'h00;
  // List modes
  localparam logic [1:0]  LIST_DISABLED   = 2'h0;
  localparam logic [1:0]  array_list_mode = 2'h1;
  // Bus answers
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // Timing and sizes
  localparam int SYS_CLK_MHZ      = 100;
  localparam int RELEASE_READY_NS = 125;
  localparam int READY_CYC_RAW    = (RELEASE_READY_NS * SYS_CLK_MHZ) / 1000;
  localparam int READY_CYC        = (READY_CYC_RAW < 1) ? 1 : READY_CYC_RAW;
  localparam int FIFO_DEPTH       = 16;
  localparam int BYTE_W           = 8;

  typedef struct packed {
    logic polarity;   // 1: clock_low_active, idles high
    logic phase;      // 1: sample on trailing edge
    logic bit_order;  // 1: low_bit_leads
  } sst_cfg_t;

  typedef struct packed {
    logic        sck;
    logic        csn_n;
    logic        mosi;
  } sst_pins_t;
endpackage

// ---- hw/sst_top.sv ----
// SPI slave transmit DMA and serial format block with AXI4-Lite registers and byte FIFO
// Contract
// - Fetch MISO bytes by DMA from pointer
// - Take at most max-count bytes from buffer
// - Report bytes transmitted in last granted transaction (here phase 0 also counts a byte loaded at the final trailing edge)
// - List field: 0 disabled, 1 array list (here only stored and read back; the fetch logic ignores it)
// - Bit 0 picks MSB or LSB first
// - Phase bit selects sample and shift edges
// - Polarity bit: 0 active high, 1 low
// - Ungranted transaction sends default character
// - Past buffer end send over-read character
// - Ready within 0.125 us after release
// - Report bytes received in last transaction (here updated only at the end of a granted one)
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module sst_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  input  wire logic         flush,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wptr;
  logic [AW:0]  rptr;
  logic         full;
  logic         empty;

  assign empty     = (wptr == rptr);
  assign full      = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rptr[AW-1:0]];

  always_ff @(posedge sys_clk) begin
    if (in_valid && !full) begin
      mem[wptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wptr <= '0;
      rptr <= '0;
    end else if (flush) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      if (in_valid && !full) begin
        wptr <= wptr + (AW + 1)'(1);
      end
      if (out_ready && !empty) begin
        rptr <= rptr + (AW + 1)'(1);
      end
    end
  end
endmodule // sst_fifo

module sst_top (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // AXI4-Lite slave
  input  wire logic [31:0] s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [31:0] s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // Byte read port toward memory
  output logic             rd_valid,
  input  wire logic        rd_ready,
  output logic [31:0]      rd_addr,
  input  wire logic        rd_rvalid,
  input  wire logic [7:0]  rd_rdata,
  // Buffer hand-over from the semaphore logic
  input  wire logic        grant_release,
  output logic             xfer_ready,
  output logic             xfer_end,
  // Received bytes
  output logic [7:0]       rx_byte,
  output logic             rx_valid,
  // SPI pins
  input  wire logic        sck,
  input  wire logic        csn_n,
  input  wire logic        mosi,
  output logic             miso,
  output logic             miso_oe
);
  // Registers
  logic [31:0]       tx_buffer_pointer;
  logic [15:0]       tx_max_bytes;
  logic [15:0]       tx_sent_count;
  logic [15:0]       rx_received_count;
  logic [1:0]        tx_list_type;
  sst_pkg::sst_cfg_t cfg;
  logic [7:0]        ignored_fill_character;
  logic [7:0]        overread_fill_character;

  // ---------------- AXI4-Lite slave ----------------
  logic        aw_full;
  logic        w_full;
  logic [11:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        wr_do;
  logic        next_aw_full;
  logic        next_w_full;
  logic        next_rvalid;
  logic        wr_hit;
  logic [31:0] rd_word;
  logic        rd_hit;

  assign wr_do        = aw_full && w_full && !s_bvalid;
  assign next_aw_full = (aw_full || (s_awvalid && s_awready)) && !wr_do;
  assign next_w_full  = (w_full || (s_wvalid && s_wready)) && !wr_do;
  assign next_rvalid  = (s_arvalid && s_arready) || (s_rvalid && !s_rready);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      aw_full   <= 1'b0;
      w_full    <= 1'b0;
      s_awready <= 1'b0;
      s_wready  <= 1'b0;
      aw_addr_q <= 12'h000;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else begin
      aw_full   <= next_aw_full;
      w_full    <= next_w_full;
      s_awready <= !next_aw_full;
      s_wready  <= !next_w_full;
      if (s_awvalid && s_awready) begin
        aw_addr_q <= s_awaddr[11:0];
      end
      if (s_wvalid && s_wready) begin
        w_data_q <= s_wdata;
        w_strb_q <= s_wstrb;
      end
    end
  end

  always_comb begin
    case (aw_addr_q)
      sst_pkg::OFF_TX_BUFFER_POINTER, sst_pkg::OFF_TX_MAX_BYTES, sst_pkg::OFF_TX_SENT_COUNT,
      sst_pkg::OFF_TX_LIST_TYPE, sst_pkg::OFF_SERIAL_FORMAT, sst_pkg::OFF_IGNORED_FILL,
      sst_pkg::OFF_OVERREAD_FILL, sst_pkg::OFF_RX_RECEIVED_COUNT,
      sst_pkg::OFF_LINK_STATUS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_bvalid <= 1'b0;
      s_bresp  <= sst_pkg::RESP_OKAY;
    end else if (wr_do) begin
      s_bvalid <= 1'b1;
      s_bresp  <= wr_hit ? sst_pkg::RESP_OKAY : sst_pkg::RESP_SLVERR;
    end else if (s_bready) begin
      s_bvalid <= 1'b0;
    end
  end

  // One storage per writable address; writes to the count and status offsets are dropped
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tx_buffer_pointer       <= sst_pkg::RST_POINTER;
      tx_max_bytes            <= sst_pkg::RST_MAX_BYTES;
      tx_list_type            <= sst_pkg::RST_LIST;
      cfg                     <= sst_pkg::RST_CONFIG;
      ignored_fill_character  <= sst_pkg::RST_FILL;
      overread_fill_character <= sst_pkg::RST_FILL;
    end else if (wr_do) begin
      case (aw_addr_q)
        sst_pkg::OFF_TX_BUFFER_POINTER: tx_buffer_pointer <=
          merge(tx_buffer_pointer, w_data_q, w_strb_q);
        sst_pkg::OFF_TX_MAX_BYTES: begin
          if (w_strb_q[0]) tx_max_bytes[7:0] <= w_data_q[7:0];
          if (w_strb_q[1]) tx_max_bytes[15:8] <= w_data_q[15:8];
        end
        sst_pkg::OFF_TX_LIST_TYPE: if (w_strb_q[0]) tx_list_type <= w_data_q[1:0];
        sst_pkg::OFF_SERIAL_FORMAT: if (w_strb_q[0]) cfg <= w_data_q[2:0];
        sst_pkg::OFF_IGNORED_FILL: if (w_strb_q[0]) ignored_fill_character <= w_data_q[7:0];
        sst_pkg::OFF_OVERREAD_FILL: if (w_strb_q[0]) overread_fill_character <= w_data_q[7:0];
        default: ;
      endcase
    end
  end

  // Read side
  logic granted;
  logic cs_act;

  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    case (s_araddr[11:0])
      sst_pkg::OFF_TX_BUFFER_POINTER: rd_word = tx_buffer_pointer;
      sst_pkg::OFF_TX_MAX_BYTES:      rd_word = {16'h0000, tx_max_bytes};
      sst_pkg::OFF_TX_SENT_COUNT:     rd_word = {16'h0000, tx_sent_count};
      sst_pkg::OFF_RX_RECEIVED_COUNT: rd_word = {16'h0000, rx_received_count};
      sst_pkg::OFF_TX_LIST_TYPE:      rd_word = {30'h0000_0000, tx_list_type};
      sst_pkg::OFF_SERIAL_FORMAT:     rd_word = {29'h0000_0000, cfg};
      sst_pkg::OFF_IGNORED_FILL:      rd_word = {24'h00_0000, ignored_fill_character};
      sst_pkg::OFF_OVERREAD_FILL:     rd_word = {24'h00_0000, overread_fill_character};
      sst_pkg::OFF_LINK_STATUS:       rd_word = {29'h0000_0000, xfer_ready, cs_act, granted};
      default:                        rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_rvalid  <= 1'b0;
      s_arready <= 1'b0;
      s_rdata   <= 32'h0000_0000;
      s_rresp   <= sst_pkg::RESP_OKAY;
    end else begin
      s_rvalid  <= next_rvalid;
      s_arready <= !next_rvalid;
      if (s_arvalid && s_arready) begin
        s_rdata <= rd_word;
        s_rresp <= rd_hit ? sst_pkg::RESP_OKAY : sst_pkg::RESP_SLVERR;
      end
    end
  end

  // ---------------- Pin synchronisers ----------------
  sst_pkg::sst_pins_t pins_raw;
  sst_pkg::sst_pins_t pins_meta;
  sst_pkg::sst_pins_t pins_s;
  sst_pkg::sst_pins_t pins_d;

  assign pins_raw = '{sck: sck, csn_n: csn_n, mosi: mosi};

  for (genvar g = 0; g < 3; g++) begin : g_sync
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        pins_meta[g] <= 1'b1;
        pins_s[g]    <= 1'b1;
        pins_d[g]    <= 1'b1;
      end else begin
        pins_meta[g] <= pins_raw[g];
        pins_s[g]    <= pins_meta[g];
        pins_d[g]    <= pins_s[g];
      end
    end
  end

  // Normalise so that the active level is high whatever the polarity
  logic act_now;
  logic act_prev;
  logic lead_e;
  logic trail_e;
  logic sample_e;
  logic shift_e;
  logic cs_start;
  logic cs_end;

  assign act_now  = pins_s.sck ^ cfg.polarity;
  assign act_prev = pins_d.sck ^ cfg.polarity;
  assign cs_act   = !pins_s.csn_n && !pins_d.csn_n;
  assign cs_start = !pins_s.csn_n && pins_d.csn_n;
  assign cs_end   = pins_s.csn_n && !pins_d.csn_n;
  assign lead_e   = cs_act && act_now && !act_prev;
  assign trail_e  = cs_act && !act_now && act_prev;
  assign sample_e = cfg.phase ? trail_e : lead_e;
  assign shift_e  = cfg.phase ? lead_e : trail_e;

  // ---------------- Grant and DMA fetch ----------------
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [7:0]  fifo_out_data;
  logic        fifo_pop;
  logic        fifo_flush;
  logic        outstanding;
  logic        drop_resp;
  logic [15:0] fetch_cnt;
  logic [15:0] tx_cnt;
  logic [4:0]  ready_timer;

  assign fifo_flush = grant_release || cs_end;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      granted <= 1'b0;
    end else if (grant_release) begin
      granted <= 1'b1; // Set wins over a coincident end of frame
    end else if (cs_end) begin
      granted <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rd_valid    <= 1'b0;
      rd_addr     <= sst_pkg::RST_POINTER;
      fetch_cnt   <= sst_pkg::RST_COUNT;
      outstanding <= 1'b0;
      drop_resp   <= 1'b0;
    end else begin
      if (rd_valid && rd_ready) begin
        rd_valid    <= 1'b0;
        outstanding <= 1'b1;
        rd_addr     <= rd_addr + 32'h0000_0001;
      end else if (!rd_valid && !outstanding && granted && !fifo_flush &&
                   fetch_cnt < tx_max_bytes && fifo_in_ready) begin
        rd_valid  <= 1'b1;
        fetch_cnt <= fetch_cnt + 16'h0001;
      end
      if (rd_rvalid) begin
        outstanding <= 1'b0;
        drop_resp   <= 1'b0;
      end
      // A read in flight across a hand-over belongs to the old buffer
      if (fifo_flush && (rd_valid || outstanding)) begin
        drop_resp <= 1'b1;
      end
      if (grant_release) begin
        rd_addr   <= tx_buffer_pointer;
        fetch_cnt <= sst_pkg::RST_COUNT;
        if (!(rd_valid && !rd_ready)) begin
          rd_valid <= 1'b0;
        end
      end
    end
  end

  sst_fifo #(
    .W (sst_pkg::BYTE_W),
    .D (sst_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .flush     (fifo_flush),
    .in_valid  (rd_rvalid && granted && !drop_resp),
    .in_ready  (fifo_in_ready),
    .in_data   (rd_rdata),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  // Ready once data is prefetched, or after the start time even if memory is slow
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ready_timer <= 5'h00;
      xfer_ready  <= 1'b0;
    end else begin
      if (grant_release) begin
        ready_timer <= 5'(sst_pkg::READY_CYC - 1);
      end else if (ready_timer != 5'h00) begin
        ready_timer <= ready_timer - 5'h01;
      end
      xfer_ready <= granted && !cs_end &&
                    (ready_timer == 5'h00 || fifo_out_valid || tx_max_bytes == 16'h0000);
    end
  end

  // ---------------- Shifter ----------------
  logic       load_now;
  logic [7:0] load_byte;
  logic [7:0] tx_sh;
  logic [7:0] rx_sh;
  logic [7:0] rx_next;
  logic [2:0] bit_cnt;
  logic       need_load;

  assign load_now = (cs_start && !cfg.phase) || (shift_e && need_load);

  always_comb begin
    fifo_pop  = 1'b0;
    load_byte = ignored_fill_character;
    if (granted) begin
      if (tx_cnt >= tx_max_bytes) begin
        load_byte = overread_fill_character;
      end else if (fifo_out_valid) begin
        load_byte = fifo_out_data;
        fifo_pop  = load_now;
      end
    end
  end

  assign rx_next = cfg.bit_order ? {pins_s.mosi, rx_sh[7:1]} : {rx_sh[6:0], pins_s.mosi};

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tx_sh     <= 8'h00;
      miso      <= 1'b0;
      miso_oe   <= 1'b0;
      need_load <= 1'b0;
    end else begin
      miso_oe <= !pins_s.csn_n;
      if (cs_start && cfg.phase) begin
        need_load <= 1'b1; // First leading edge shifts the first bit
      end else if (load_now) begin
        tx_sh     <= load_byte;
        miso      <= cfg.bit_order ? load_byte[0] : load_byte[7];
        need_load <= 1'b0;
      end else if (shift_e) begin
        tx_sh <= cfg.bit_order ? {1'b0, tx_sh[7:1]} : {tx_sh[6:0], 1'b0};
        miso  <= cfg.bit_order ? tx_sh[1] : tx_sh[6];
      end
      if (sample_e && bit_cnt == 3'h7) begin
        need_load <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rx_sh    <= 8'h00;
      bit_cnt  <= 3'h0;
      rx_byte  <= 8'h00;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (cs_start) begin
        bit_cnt <= 3'h0;
      end else if (sample_e) begin
        rx_sh   <= rx_next;
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == 3'h7) begin
          rx_byte  <= rx_next;
          rx_valid <= 1'b1;
        end
      end
    end
  end

  // ---------------- Transaction counters ----------------
  logic [15:0] rx_cnt;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tx_cnt            <= sst_pkg::RST_COUNT;
      rx_cnt            <= sst_pkg::RST_COUNT;
      tx_sent_count     <= sst_pkg::RST_COUNT;
      rx_received_count <= sst_pkg::RST_COUNT;
      xfer_end          <= 1'b0;
    end else begin
      xfer_end <= 1'b0;
      if (grant_release || cs_start) begin
        // In phase 0 the first byte is popped at select and must be counted
        tx_cnt <= fifo_pop ? 16'h0001 : sst_pkg::RST_COUNT;
        rx_cnt <= sst_pkg::RST_COUNT;
      end else begin
        if (fifo_pop) begin
          tx_cnt <= tx_cnt + 16'h0001;
        end
        if (sample_e && bit_cnt == 3'h7 && rx_cnt != 16'hffff) begin
          rx_cnt <= rx_cnt + 16'h0001;
        end
      end
      if (cs_end && granted) begin
        tx_sent_count     <= tx_cnt;
        rx_received_count <= rx_cnt;
        xfer_end          <= 1'b1;
      end
    end
  end
endmodule // sst_top

`default_nettype wire

// ---- testbench/spi_slave_tx_dma_config_bench.sv ----
// Self-checking bench: registers over AXI4-Lite, memory model and SPI frames
`timescale 1ns/1ps
`default_nettype none
module spi_slave_tx_dma_config_bench;
  logic        sys_clk = 1'b0, resetn = 1'b0;
  logic [31:0] s_awaddr = 32'h0, s_wdata = 32'h0, s_araddr = 32'h0, s_rdata, rd_addr;
  logic [3:0]  s_wstrb = 4'hf;
  logic        s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0;
  logic        s_rready = 1'b0, rd_ready = 1'b0, rd_rvalid = 1'b0, grant_release = 1'b0;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, rd_valid;
  logic        xfer_ready, xfer_end, rx_valid, sck, csn_n, mosi, miso, miso_oe;
  logic [1:0]  s_bresp, s_rresp;
  logic [7:0]  rd_rdata = 8'h0, rx_byte;
  logic [31:0] la = 32'h0;
  int          lat = 0, n_fail = 0, checked = 0, n_rx = 0, n_end = 0;
  localparam logic [11:0] RWA [6] = '{12'h544, 12'h548, 12'h550, 12'h554, 12'h55c, 12'h5c0};
  localparam logic [31:0] RWM [6] = '{32'hffffffff, 32'hffff, 32'h3, 32'h7, 32'hff, 32'hff};

  sst_top i_dut (.sys_clk, .resetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
    .s_rdata, .s_rresp, .s_rvalid, .s_rready, .rd_valid, .rd_ready, .rd_addr, .rd_rvalid,
    .rd_rdata, .grant_release, .xfer_ready, .xfer_end, .rx_byte, .rx_valid, .sck, .csn_n,
    .mosi, .miso, .miso_oe);
  sst_spi_master i_mst (.miso, .sck, .csn_n, .mosi);

  always #5 sys_clk = ~sys_clk;

  function automatic logic [7:0] mb(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction

  // Pulse outputs are counted so that a missing or doubled pulse shows up
  always @(posedge sys_clk) begin
    if (rx_valid === 1'b1) n_rx++;
    if (xfer_end === 1'b1) n_end++;
  end

  // Memory answers with random stalls and latency; idle data toggles every cycle
  always @(posedge sys_clk) begin
    rd_ready <= 1'($urandom_range(1, 0));
    if (lat == 1) begin
      rd_rvalid <= 1'b1;
      rd_rdata <= mb(la);
    end else begin
      rd_rvalid <= 1'b0;
      rd_rdata <= ~rd_rdata;
    end
    if (lat > 0) lat--;
    if (rd_valid && rd_ready) begin
      la = rd_addr;
      lat = $urandom_range(3, 1);
    end
  end

  task automatic wrap_up();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic tmo(input int t, input int lim);
    if (t >= lim) begin
      n_fail++;
      $display("[FAIL] wait expected done seen timeout");
      wrap_up();
    end
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int t;
    @(posedge sys_clk);
    t = 0;
    s_awaddr <= {20'h0, a};
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'($urandom_range(1, 0));
    do begin
      @(posedge sys_clk);
      t++;
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
      if (!(s_bvalid && s_bready)) s_bready <= 1'b1;
    end while (!(s_bvalid && s_bready) && t < 99);
    r = s_bresp;
    s_bready <= 1'b0;
    tmo(t, 99);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int t;
    @(posedge sys_clk);
    t = 0;
    s_araddr <= {20'h0, a};
    s_arvalid <= 1'b1;
    s_rready <= 1'($urandom_range(1, 0));
    do begin
      @(posedge sys_clk);
      t++;
      if (s_arready) s_arvalid <= 1'b0;
      if (!(s_rvalid && s_rready)) s_rready <= 1'b1;
    end while (!(s_rvalid && s_rready) && t < 99);
    d = s_rdata;
    r = s_rresp;
    s_rready <= 1'b0;
    tmo(t, 99);
  endtask

  initial begin
    int c, k, t;
    logic [31:0] v, p, x, o, m;
    logic [1:0] r;
    void'($urandom(71864));
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    for (k = 0; k < 6; k++) begin
      rd(RWA[k], v, r);
      chk("reset value", 32'h0, v);
      x = $urandom;
      wr(RWA[k], x, r);
      rd(RWA[k], v, r);
      chk("readback", x & RWM[k], v);
    end
    rd(sst_pkg::OFF_TX_SENT_COUNT, v, r);
    chk("sent reset", 32'h0, v);
    wr(sst_pkg::OFF_TX_SENT_COUNT, $urandom, r);
    rd(sst_pkg::OFF_TX_SENT_COUNT, v, r);
    chk("sent read only", 32'h0, v);
    wr(12'h600, 32'h1, r);
    chk("unmapped write", 32'(sst_pkg::RESP_SLVERR), 32'(r));
    rd(12'h600, v, r);
    chk("unmapped read", 32'(sst_pkg::RESP_SLVERR), 32'(r));
    o = $urandom_range(255, 0);
    wr(sst_pkg::OFF_SERIAL_FORMAT, 32'h0, r);
    wr(sst_pkg::OFF_IGNORED_FILL, o, r);
    i_mst.frame(2, 8'h3c);
    for (k = 0; k < 2; k++) chk("ignored fill", o, 32'(i_mst.got[k]));
    for (c = 0; c < 8; c++) begin
      p = $urandom;
      m = $urandom_range(4, 1);
      o = $urandom_range(255, 0);
      x = $urandom_range(255, 0);
      wr(sst_pkg::OFF_SERIAL_FORMAT, 32'(c), r);
      wr(sst_pkg::OFF_TX_LIST_TYPE, 32'(c % 2), r);
      wr(sst_pkg::OFF_TX_BUFFER_POINTER, p, r);
      wr(sst_pkg::OFF_TX_MAX_BYTES, m, r);
      wr(sst_pkg::OFF_OVERREAD_FILL, o, r);
      {i_mst.cpol, i_mst.cpha, i_mst.lsb} = c[2:0];
      @(posedge sys_clk);
      grant_release <= 1'b1;
      @(posedge sys_clk);
      grant_release <= 1'b0;
      for (t = 0; xfer_ready !== 1'b1 && t < 16; t++) @(posedge sys_clk);
      tmo(t, 16);
      i_mst.frame(5, x[7:0]);
      for (k = 0; k < 5; k++) begin
        v = (k < m) ? 32'(mb(p + k)) : o;
        chk("miso byte", v, 32'(i_mst.got[k]));
      end
      rd(sst_pkg::OFF_TX_SENT_COUNT, v, r);
      chk("sent count", m, v);
      rd(12'h53c, v, r);
      chk("received count", 32'h5, v);
      chk("last rx byte", x, 32'(rx_byte));
      chk("rx pulses", 32'(7 + 5 * c), 32'(n_rx));
      chk("frame ends", 32'(c + 1), 32'(n_end));
      chk("drive off", 32'h0, 32'(miso_oe));
    end
    wrap_up();
  end
endmodule // spi_slave_tx_dma_config_bench
`default_nettype wire

// ---- testbench/sst_spi_master.sv ----
// Behavioural SPI master that clocks frames and captures the slave's serial data
`timescale 1ns/1ps
`default_nettype none
module sst_spi_master (
  input  wire logic miso,
  output logic      sck,
  output logic      csn_n,
  output logic      mosi
);
  logic [7:0] got [8];
  logic       cpol = 1'b0;
  logic       cpha = 1'b0;
  logic       lsb  = 1'b0;
  initial begin
    sck = 1'b0;
    csn_n = 1'b1;
    mosi = 1'b0;
  end
  // Clock stands still at its idle level outside frames
  task automatic frame(input int n, input logic [7:0] tx);
    int i, b, k;
    sck = cpol;
    #300 csn_n = 1'b0;
    #1000;
    for (i = 0; i < n; i++) begin
      for (b = 0; b < 8; b++) begin
        k = lsb ? b : 7 - b;
        if (!cpha) mosi = tx[k];
        #62.5 sck = ~cpol;
        if (cpha) mosi = tx[k];
        else got[i][k] = miso;
        #62.5 sck = cpol;
        if (cpha) got[i][k] = miso;
      end
    end
    #1000 csn_n = 1'b1;
    mosi = ~mosi;
    #100;
  endtask
endmodule // sst_spi_master
`default_nettype wire

// ---- testbench/sst_top_sva.sv ----
// Checker of bus handshakes, fetch port and frame end of the SPI slave TX block
`timescale 1ns/1ps
`default_nettype none
module sst_top_sva (
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic        s_awvalid,
  input wire logic        s_awready,
  input wire logic        s_wvalid,
  input wire logic        s_wready,
  input wire logic [1:0]  s_bresp,
  input wire logic        s_bvalid,
  input wire logic        s_bready,
  input wire logic        s_arvalid,
  input wire logic        s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic        s_rvalid,
  input wire logic        s_rready,
  input wire logic        rd_valid,
  input wire logic        rd_ready,
  input wire logic [31:0] rd_addr,
  input wire logic        xfer_ready,
  input wire logic        xfer_end,
  input wire logic        csn_n
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  sequence w_take;
    s_awvalid && s_awready && s_wvalid && s_wready;
  endsequence
  sequence r_take;
    s_arvalid && s_arready;
  endsequence
  ar_answer_a: assert property (r_take |=> s_rvalid && !s_arready)
    else $error("read answer late");
  r_hold_a: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read data dropped");
  b_hold_a: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("write answer dropped");
  b_answer_a: assert property (w_take |-> !s_bvalid ##2 s_bvalid)
    else $error("write answer timing");
  fetch_hold_a: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_addr))
    else $error("fetch request dropped");
  end_pulse_a: assert property (xfer_end |=> !xfer_end)
    else $error("frame end not a pulse");
  end_cs_a: assert property (xfer_end |-> csn_n)
    else $error("frame end while selected");
  grant_gone_a: assert property (xfer_end |-> ##2 !xfer_ready)
    else $error("grant kept after frame");
endmodule // sst_top_sva
bind sst_top sst_top_sva i_sva (
  .sys_clk, .resetn, .s_awvalid, .s_awready, .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
  .s_bready, .s_arvalid, .s_arready, .s_rdata, .s_rvalid, .s_rready, .rd_valid,
  .rd_ready, .rd_addr, .xfer_ready, .xfer_end, .csn_n
);
`default_nettype wire
